// [agoc_ctrl.sv]
// Gain, offset correction and power-state control for a dual-channel converter.
// Assumes host control bits are synchronous; power pins and rate tick are asynchronous.
`timescale 1ns/1ps
module agoc_ctrl #(
   parameter int WAKE_GPD_CYCLES = agoc_pkg::WAKE_GPD_CYC
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [3:0] gainCode,
   input wire logic offsetCorrEn,
   input wire logic [3:0] offset_loop_tc_select,
   input wire logic serialMode,
   input wire logic lowSpeedEn,
   input wire logic [3:0] powerStateField,
   input wire agoc_pkg::agoc_pins_t powerPins,
   input wire logic sampleRateTick,
   input wire agoc_pkg::agoc_samp_t sampIn,
   output logic [3:0] gainApplied,
   output logic [15:0] fullScaleMv,
   output agoc_pkg::agoc_samp_t sampOut,
   output logic chanAOutEn,
   output logic chanBOutEn,
   output logic sharedBusInterleave,
   output logic sharedBusPhaseA,
   output logic refPowered,
   output logic adcAPowered,
   output logic adcBPowered,
   output logic dataValidA,
   output logic dataValidB,
   output logic lowPowerClk
);
   import agoc_pkg::*;

   agoc_state_t q, d;
   // One corrected sample per channel, indexed by the loop that makes it
   logic signed [DW-1:0] corrCh [2];
   logic [2:0] pinCode;
   logic signed [24:0] prodA, prodB;
   logic tickEdge;

   // ==========================================
   // Offset loops, one per channel
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_loop
         agoc_offset_loop u_loop (
            .clk(clk),
            .sys_rst(sys_rst),
            .corrEn(offsetCorrEn),
            .tcSelect(offset_loop_tc_select),
            .sampIn(ch == 0 ? sampIn.a : sampIn.b),
            .sampOut(corrCh[ch]),
            .estOut()
         );
      end
   endgenerate

   // ==========================================
   // Next state
   always_comb begin
      d = q;
      // Pins and rate tick: three flops, a change counts once stages two and three agree
      d.sync1 = {sampleRateTick, powerPins};
      d.sync2 = q.sync1;
      d.sync3 = q.sync2;
      for (int i = 0; i < 4; i++) begin
         if (q.sync2[i] == q.sync3[i]) begin
            d.pinStable[i] = q.sync3[i];
         end
      end
      pinCode = q.pinStable[2:0];

      // Sample rate watch: no tick edge for a full slow period means low power
      d.tickPrev = q.pinStable[3];
      tickEdge = q.pinStable[3] != q.tickPrev;
      if (tickEdge) begin
         d.gapCnt = '0;
      end else if (q.gapCnt < LOW_RATE_CYC) begin
         d.gapCnt = q.gapCnt + 8'h01;
      end
      d.lowPower = d.gapCnt >= LOW_RATE_CYC; // [R14]

      // Gain: out-of-range codes are ignored
      if (gainCode <= GAIN_MAX) begin
         d.gain = gainCode; // [R1]
      end
      d.gainQ10 = agoc_gain_q10(d.gain); // [R1]
      d.fsMv = agoc_fs_mv(d.gain); // [R3]

      // Power state decode
      d.mode = MODE_NORMAL; // [R15]
      if (serialMode) begin
         unique case (powerStateField)
            PS_BOFF_B: d.mode = MODE_BOFF_B; // [R9]
            PS_BOFF_A: d.mode = MODE_BOFF_A; // [R9]
            PS_BOFF_AB: d.mode = MODE_BOFF_AB; // [R9]
            PS_GPD: d.mode = MODE_GPD; // [R10]
            PS_STBY_B: d.mode = MODE_STBY_B; // [R11]
            PS_STBY_A: d.mode = MODE_STBY_A; // [R11]
            // Interleave only makes sense at low speed
            PS_MUX: d.mode = lowSpeedEn ? MODE_MUX : MODE_NORMAL; // [R12]
            default: d.mode = MODE_NORMAL; // [R15]
         endcase
      end else begin
         // No pin code reaches buffer-disable or interleave
         unique case (pinCode)
            PIN_GPD: d.mode = MODE_GPD; // [R13]
            PIN_STBY_B: d.mode = MODE_STBY_B; // [R13]
            PIN_STBY_A: d.mode = MODE_STBY_A; // [R13]
            default: d.mode = MODE_NORMAL; // [R13]
         endcase
      end

      // Blocks powered and buffers driven per mode
      d.refOn = d.mode != MODE_GPD; // [R10] [R11]
      d.adcAOn = !(d.mode inside {MODE_GPD, MODE_STBY_A}); // [R11]
      d.adcBOn = !(d.mode inside {MODE_GPD, MODE_STBY_B}); // [R11]
      d.oeA = !(d.mode inside {MODE_GPD, MODE_BOFF_A, MODE_BOFF_AB}); // [R9] [R10]
      d.oeB = !(d.mode inside {MODE_GPD, MODE_BOFF_B, MODE_BOFF_AB, MODE_MUX}); // [R9]
      d.shared_bus_interleave = d.mode == MODE_MUX; // [R12]

      // Wake-up: long after full power-down, short after standby
      if (q.mode == MODE_GPD && d.mode != MODE_GPD) begin
         d.wakeCnt = 13'(WAKE_GPD_CYCLES); // [R10]
      end else if ((q.mode == MODE_STBY_A || q.mode == MODE_STBY_B) && d.mode != q.mode) begin
         d.wakeCnt = WAKE_STBY_CYC; // [R11]
      end else if (q.wakeCnt != '0) begin
         d.wakeCnt = q.wakeCnt - 13'h0001;
      end
      d.validA = d.adcAOn && d.wakeCnt == '0 && !d.lowPower; // [R14]
      d.validB = d.adcBOn && d.wakeCnt == '0 && !d.lowPower; // [R14]

      // Gain applied after offset correction, saturated to the code range
      prodA = 25'(corrCh[0] * $signed({1'b0, q.gainQ10})) >>> 10;
      prodB = 25'(corrCh[1] * $signed({1'b0, q.gainQ10})) >>> 10;
      d.muxPhase = d.shared_bus_interleave ? !q.muxPhase : 1'b0;
      d.out.a = d.validA ? agoc_sat(prodA) : '0;
      d.out.b = d.validB ? agoc_sat(prodB) : '0;
      // Interleave: B on one phase, A on the next; B bus itself is idle
      if (d.shared_bus_interleave) begin
         d.out.a = d.muxPhase ? d.out.a : d.out.b; // [R12]
         d.out.b = '0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         q <= '0;
         q.gain <= GAIN_RST; // [R2]
         q.gainQ10 <= GAIN_Q10[0];
         q.fsMv <= FS_MV[0];
         q.mode <= MODE_NORMAL;
      end else begin
         q <= d;
      end
   end

   assign gainApplied = q.gain;
   assign fullScaleMv = q.fsMv;
   assign sampOut = q.out;
   assign chanAOutEn = q.oeA;
   assign chanBOutEn = q.oeB;
   assign sharedBusInterleave = q.shared_bus_interleave;
   assign sharedBusPhaseA = q.muxPhase;
   assign refPowered = q.refOn;
   assign adcAPowered = q.adcAOn;
   assign adcBPowered = q.adcBOn;
   assign dataValidA = q.validA;
   assign dataValidB = q.validB;
   assign lowPowerClk = q.lowPower;

   // ==========================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence leave_gpd_s;
      $past(q.mode) == MODE_GPD && q.mode != MODE_GPD;
   endsequence

   sequence leave_stby_s;
      $past(q.mode) inside {MODE_STBY_A, MODE_STBY_B} && q.mode != $past(q.mode);
   endsequence

   sequence pin_gpd_s;
      !serialMode && q.pinStable[2:0] == 3'h1;
   endsequence

   gain_reset_a: assert property (disable iff (1'b0) sys_rst |=> q.gain == GAIN_RST) // [R2]
      else $error("gain not 0 dB after reset");
   gain_range_a: assert property (gainApplied <= GAIN_MAX) // [R1]
      else $error("gain code out of range");
   gain_take_a: assert property (gainCode <= GAIN_MAX |=> gainApplied == $past(gainCode)) // [R1]
      else $error("gain code not applied");
   fs_track_a: assert property (gainApplied == 4'hC |-> fullScaleMv == 16'h03E8) // [R3]
      else $error("full scale at 6 dB not 1 V");
   buf_off_a: assert property (serialMode && powerStateField == 4'hB |=> !chanAOutEn
      && !chanBOutEn && adcAPowered && adcBPowered) // [R9]
      else $error("both buffers not disabled");
   buf_b_a: assert property (serialMode && powerStateField == PS_BOFF_B |=> !chanBOutEn
      && chanAOutEn) // [R9]
      else $error("channel B buffer not disabled alone");
   buf_a_a: assert property (serialMode && powerStateField == PS_BOFF_A |=> !chanAOutEn
      && chanBOutEn) // [R9]
      else $error("channel A buffer not disabled alone");
   gpd_off_a: assert property (q.mode == MODE_GPD |-> !chanAOutEn && !chanBOutEn
      && !refPowered && !dataValidA && !dataValidB) // [R10]
      else $error("global power-down left something on");
   gpd_wake_a: assert property (leave_gpd_s |-> q.wakeCnt == 13'(WAKE_GPD_CYCLES)
      ##1 !dataValidA [*8]) // [R10]
      else $error("slow wake not started");
   stby_b_a: assert property (q.mode == MODE_STBY_B |-> refPowered && !adcBPowered
      && adcAPowered) // [R11]
      else $error("channel B standby wrong");
   stby_a_a: assert property (q.mode == MODE_STBY_A |-> refPowered && !adcAPowered
      && adcBPowered) // [R11]
      else $error("channel A standby wrong");
   stby_wake_a: assert property (leave_stby_s |-> q.wakeCnt == WAKE_STBY_CYC
      ##1 (!dataValidA && !dataValidB) [*8]) // [R11]
      else $error("fast wake not started");
   // Output lags the request by one edge, so the gate is judged on last cycle's inputs
   mux_gate_a: assert property (sharedBusInterleave |-> $past(serialMode && lowSpeedEn)
      && !chanBOutEn) // [R12]
      else $error("interleave without serial low-speed");
   mux_phase_a: assert property (sharedBusInterleave && $past(sharedBusInterleave)
      |-> sharedBusPhaseA != $past(sharedBusPhaseA)) // [R12]
      else $error("interleave phase not alternating");
   mux_b_idle_a: assert property (sharedBusInterleave |-> sampOut.b == '0) // [R12]
      else $error("channel B bus not idle in interleave");
   pin_gpd_a: assert property (pin_gpd_s |=> q.mode == MODE_GPD) // [R13]
      else $error("pin power-down not decoded");
   low_rate_a: assert property (lowPowerClk |-> !dataValidA && !dataValidB) // [R14]
      else $error("data valid while clock too slow");
   undef_code_a: assert property (serialMode && powerStateField inside {[4'h1:4'h8]}
      |=> q.mode == MODE_NORMAL) // [R15]
      else $error("unassigned code not normal");

endmodule // agoc_ctrl

// [agoc_pkg.sv]
// Constants, types and helpers for the converter gain, offset and power control.
// Assumes one 200 MHz sample-domain clock and host control bits driven as plain ports.
// What this block does
// R1 - Gain accepted from 0 to 6 dB in half-dB steps, applied to samples.
// R2 - Gain is 0 dB after reset until host writes another value.
// R3 - Full-scale range shrinks with gain, 2 V at 0 dB down to 1 V.
// R4 - Offset loop estimates and cancels up to ten millivolts per channel.
// R5 - With correction enabled, estimate updates and correction applies every cycle.
// R6 - Four-bit field picks loop time constant 256k doubling to 512M; top codes reserved.
// R7 - Clearing enable freezes the estimate, which is still applied every cycle.
// R8 - Correction is disabled after reset; nothing estimates until host enables it.
// R9 - Power field: 0000 normal, 1001/1010/1011 disable B, A, both output buffers.
// R10 - Code 1100 powers everything down, outputs off, about 30 us to wake.
// R11 - 1101 stands channel B by, 1110 channel A; references stay up, 1 us wake.
// R12 - 1111 interleaves both channels on bus A; needs low-speed mode, serial only.
// R13 - Parallel pins: LLL normal, HLL power-down, HLH B standby, HHL A standby.
// R14 - Sample rate below one mega-sample per second forces a low-power state.
// R15 - Unassigned power field codes behave as normal operation.
package agoc_pkg;

   // ==========================================
   // Widths, gain and offset
   localparam int DW = 11;
   localparam logic [3:0] GAIN_RST = 4'h0;
   localparam logic [3:0] GAIN_MAX = 4'hC;
   localparam logic [4:0] TC_SHIFT_BASE = 5'h12;
   localparam logic [3:0] TC_CODE_MAX = 4'hB;
   // One code is about 0.98 mV at 2 V full scale, so ten codes cover ten millivolts
   localparam logic signed [41:0] OFF_LIM = 42'sh000_0000_000A;

   // Gain multiplier, Q10, per whole dB
   localparam logic [11:0] GAIN_Q10 [0:6] = '{12'h400, 12'h47F, 12'h508, 12'h5A2,
                                              12'h659, 12'h725, 12'h800};
   // Full scale in mV per whole dB
   localparam logic [15:0] FS_MV [0:6] = '{16'h07D0, 16'h06F4, 16'h0636, 16'h058C,
                                          16'h04EC, 16'h0460, 16'h03E8};

   // ==========================================
   // Power field and pin codes
   localparam logic [3:0] PS_NORMAL = 4'h0;
   localparam logic [3:0] PS_BOFF_B = 4'h9;
   localparam logic [3:0] PS_BOFF_A = 4'hA;
   localparam logic [3:0] PS_BOFF_AB = 4'hB;
   localparam logic [3:0] PS_GPD = 4'hC;
   localparam logic [3:0] PS_STBY_B = 4'hD;
   localparam logic [3:0] PS_STBY_A = 4'hE;
   localparam logic [3:0] PS_MUX = 4'hF;
   localparam logic [2:0] PIN_NORMAL = 3'h0;
   localparam logic [2:0] PIN_GPD = 3'h1;
   localparam logic [2:0] PIN_STBY_B = 3'h5;
   localparam logic [2:0] PIN_STBY_A = 3'h3;

   // ==========================================
   // Timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int WAKE_GPD_NS = 30000;
   localparam int WAKE_STBY_NS = 1000;
   localparam int MIN_RATE_PERIOD_NS = 1000;
   localparam int WAKE_GPD_CYC = (WAKE_GPD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [12:0] WAKE_STBY_CYC =
      13'((WAKE_STBY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] LOW_RATE_CYC = 8'(MIN_RATE_PERIOD_NS / CLK_PERIOD_NS);

   // ==========================================
   // Types
   typedef enum logic [2:0] {
      MODE_NORMAL, MODE_BOFF_B, MODE_BOFF_A, MODE_BOFF_AB,
      MODE_GPD, MODE_STBY_B, MODE_STBY_A, MODE_MUX
   } agoc_mode_t;

   typedef struct packed {
      logic third;
      logic second;
      logic first;
   } agoc_pins_t;

   typedef struct packed {
      logic signed [DW-1:0] a;
      logic signed [DW-1:0] b;
   } agoc_samp_t;

   typedef struct packed {
      logic signed [41:0] acc;
      logic [4:0] shift;
      logic signed [DW-1:0] est;
      logic signed [DW-1:0] out;
   } agoc_loop_t;

   typedef struct packed {
      logic [3:0] sync1;
      logic [3:0] sync2;
      logic [3:0] sync3;
      logic [3:0] pinStable;
      logic tickPrev;
      logic [7:0] gapCnt;
      logic lowPower;
      agoc_mode_t mode;
      logic [12:0] wakeCnt;
      logic [3:0] gain;
      logic [11:0] gainQ10;
      logic [15:0] fsMv;
      logic oeA;
      logic oeB;
      logic refOn;
      logic adcAOn;
      logic adcBOn;
      logic validA;
      logic validB;
      logic shared_bus_interleave;
      logic muxPhase;
      agoc_samp_t out;
   } agoc_state_t;

   // ==========================================
   // Helpers
   function automatic logic signed [DW-1:0] agoc_sat(input logic signed [24:0] v);
      if (v > 25'sh00_03FF) begin
         return 11'sh3FF;
      end else if (v < -25'sh00_0400) begin
         return -11'sh400;
      end
      return v[DW-1:0];
   endfunction

   // Half-dB steps take the midpoint of the two whole-dB neighbours
   function automatic logic [11:0] agoc_gain_q10(input logic [3:0] g);
      logic [2:0] w;
      logic [12:0] s;
      w = g[3:1];
      s = {1'b0, GAIN_Q10[w]};
      if (g[0]) begin
         s = 13'({1'b0, GAIN_Q10[w]} + {1'b0, GAIN_Q10[w + 3'h1]}) >> 1;
      end
      return s[11:0];
   endfunction

   function automatic logic [15:0] agoc_fs_mv(input logic [3:0] g);
      logic [2:0] w;
      logic [16:0] s;
      w = g[3:1];
      s = {1'b0, FS_MV[w]};
      if (g[0]) begin
         s = 17'({1'b0, FS_MV[w]} + {1'b0, FS_MV[w + 3'h1]}) >> 1;
      end
      return s[15:0];
   endfunction

endpackage

// [agoc_offset_loop.sv]
// One channel of the dc offset estimation and correction loop.
// Assumes samples arrive every clock from the converter on the same clock.
`timescale 1ns/1ps
module agoc_offset_loop (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic corrEn,
   input wire logic [3:0] tcSelect,
   input wire logic signed [agoc_pkg::DW-1:0] sampIn,
   output logic signed [agoc_pkg::DW-1:0] sampOut,
   output logic signed [agoc_pkg::DW-1:0] estOut
);
   import agoc_pkg::*;

   agoc_loop_t q, d;
   logic signed [41:0] accShift;

   // ==========================================
   // Leaky integrator: acc settles to mean times two to the shift
   always_comb begin
      d = q;
      accShift = q.acc >>> q.shift;
      // Reserved codes keep the last legal time constant
      if (tcSelect <= TC_CODE_MAX) begin
         d.shift = TC_SHIFT_BASE + 5'(tcSelect); // [R6]
      end
      if (corrEn) begin
         d.acc = q.acc + 42'(sampIn) - accShift; // [R5]
      end
      if (accShift > OFF_LIM) begin
         d.est = OFF_LIM[DW-1:0]; // [R4]
      end else if (accShift < -OFF_LIM) begin
         d.est = -OFF_LIM[DW-1:0]; // [R4]
      end else begin
         d.est = accShift[DW-1:0];
      end
      // Applied whether loop runs or is frozen
      d.out = agoc_sat(25'(sampIn) - 25'(q.est)); // [R5] [R7]
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         q <= '0; // [R8]
         q.shift <= TC_SHIFT_BASE;
      end else begin
         q <= d;
      end
   end

   assign sampOut = q.out;
   assign estOut = q.est;

   // ==========================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   freeze_hold_a: assert property (!corrEn |=> $stable(q.acc)) // [R7]
      else $error("offset estimate moved while frozen");
   est_limit_a: assert property (q.est <= 11'sh00A && q.est >= -11'sh00A) // [R4]
      else $error("offset estimate beyond ten codes");
   tc_shift_a: assert property (tcSelect == 4'h0 |=> q.shift == 5'h12) // [R6]
      else $error("shortest time constant not 256k");
   reset_clear_a: assert property (disable iff (1'b0) sys_rst |=> q.acc == '0) // [R8]
      else $error("offset estimate not cleared by reset");
   tc_hold_a: assert property (tcSelect > TC_CODE_MAX |=> $stable(q.shift)) // [R6]
      else $error("reserved time constant code changed the loop");

endmodule // agoc_offset_loop

// [agoc_host_model.sv]
// Host side model: control bits, sample source and sample-rate monitor tick.
// Assumes the bench calls its tasks; every change lands on a falling edge.
`timescale 1ns/1ps
module agoc_host_model (
   input wire logic clk,
   output logic [3:0] gainCode,
   output logic offsetCorrEn,
   output logic [3:0] offset_loop_tc_select,
   output logic serialMode,
   output logic lowSpeedEn,
   output logic [3:0] powerStateField,
   output agoc_pkg::agoc_pins_t powerPins,
   output logic sampleRateTick,
   output agoc_pkg::agoc_samp_t sampIn
);
   import agoc_pkg::*;
   logic tickRun;
   logic [1:0] tickDiv;

   // ==========================================
   // Idle values and the rate tick
   initial begin
      gainCode = 4'h0;
      offsetCorrEn = 1'b0;
      offset_loop_tc_select = 4'h0;
      serialMode = 1'b1;
      lowSpeedEn = 1'b0;
      powerStateField = PS_NORMAL;
      powerPins = 3'h0;
      sampleRateTick = 1'b0;
      sampIn = '0;
      tickRun = 1'b1;
      tickDiv = 2'h0;
   end

   // Toggles every fourth cycle; a toggle each cycle never settles through the pin filter
   // Stops to mimic a slow sample clock
   always @(negedge clk) begin
      tickDiv <= tickDiv + 2'h1;
      if (tickRun && tickDiv == 2'h3) sampleRateTick <= ~sampleRateTick;
   end

   // ==========================================
   // Host requests
   task automatic putGain(input logic [3:0] v);
      @(negedge clk);
      gainCode = v;
   endtask

   // Low speed goes up a cycle before the field, so interleave is never entered bare
   task automatic putPower(input logic sm, input logic ls, input logic [3:0] f,
      input logic [2:0] p);
      @(negedge clk);
      lowSpeedEn = ls;
      serialMode = sm;
      powerPins = p;
      @(negedge clk);
      powerStateField = f;
   endtask

   task automatic putCorr(input logic en, input logic [3:0] tc);
      @(negedge clk);
      offsetCorrEn = en;
      offset_loop_tc_select = tc;
   endtask

   task automatic putSamp(input logic [DW-1:0] a, input logic [DW-1:0] b);
      @(negedge clk);
      sampIn.a = a;
      sampIn.b = b;
   endtask

   task automatic setTick(input logic on);
      @(negedge clk);
      tickRun = on;
   endtask
endmodule // agoc_host_model

// [agoc_ctrl_tb_top.sv]
// Self-checking bench for the gain, offset and power control block.
// Assumes the host model drives all inputs but clk and sys_rst; short global wake parameter.
`timescale 1ns/1ps
module agoc_ctrl_tb_top;
   import agoc_pkg::*;
   localparam int WAKE = 50;
   // Gain requests; 13 is out of range and keeps 12
   localparam logic [3:0] G_IN [5] = '{4'h0, 4'h1, 4'h2, 4'hC, 4'hD};
   localparam logic [15:0] FS [5] = '{16'h07D0, 16'h0762, 16'h06F4, 16'h03E8, 16'h03E8};
   localparam logic [3:0] G_OUT [5] = '{4'h0, 4'h1, 4'h2, 4'hC, 4'hC};
   // Power table: serial, low speed, code, {oeA,oeB,ref,adcA,adcB,mux}, care mask
   localparam logic P_SM [15] = '{1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 0, 0, 0, 0, 0};
   localparam logic P_LS [15] = '{0, 0, 0, 0, 0, 0, 0, 0, 1, 0, 0, 0, 0, 1, 0};
   localparam logic [3:0] P_C [15] = '{4'h0, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'h5,
      4'hF, 4'hF, 4'h1, 4'h5, 4'h3, 4'h7, 4'h0};
   localparam logic [5:0] P_E [15] = '{6'h3E, 6'h2E, 6'h1E, 6'h0E, 6'h00, 6'h0C, 6'h0A,
      6'h3E, 6'h0F, 6'h3E, 6'h00, 6'h0C, 6'h0A, 6'h3E, 6'h3E};
   localparam logic [5:0] P_M [15] = '{6'h3F, 6'h3F, 6'h3F, 6'h3F, 6'h3F, 6'h0F, 6'h0F,
      6'h3F, 6'h0F, 6'h3F, 6'h3F, 6'h0F, 6'h0F, 6'h3F, 6'h3F};
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] gainCode, offset_loop_tc_select, powerStateField, gainApplied;
   logic offsetCorrEn, serialMode, lowSpeedEn, sampleRateTick;
   agoc_pins_t powerPins;
   agoc_samp_t sampIn, sampOut;
   logic [15:0] fullScaleMv;
   logic chanAOutEn, chanBOutEn, sharedBusInterleave, refPowered, adcAPowered, adcBPowered;
   logic dataValidA, dataValidB, lowPowerClk;
   logic [5:0] pwr;
   logic phaseA, ph;
   int err_total = 0;
   int num_checks = 0;
   int cnt;

   always #2.5 clk = ~clk;
   assign pwr = {chanAOutEn, chanBOutEn, refPowered, adcAPowered, adcBPowered,
      sharedBusInterleave};

   agoc_host_model i_agoc_host_model (.clk, .gainCode, .offsetCorrEn,
      .offset_loop_tc_select, .serialMode, .lowSpeedEn, .powerStateField, .powerPins,
      .sampleRateTick, .sampIn);

   // Short global wake keeps the run brief
   agoc_ctrl #(.WAKE_GPD_CYCLES(WAKE)) i_agoc_ctrl (.clk, .sys_rst, .gainCode,
      .offsetCorrEn, .offset_loop_tc_select, .serialMode, .lowSpeedEn, .powerStateField,
      .powerPins, .sampleRateTick, .sampIn, .gainApplied, .fullScaleMv, .sampOut,
      .chanAOutEn, .chanBOutEn, .sharedBusInterleave, .sharedBusPhaseA(phaseA), .refPowered,
      .adcAPowered, .adcBPowered, .dataValidA, .dataValidB, .lowPowerClk);

   // ==========================================
   // Helpers
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", what, exp, got);
         err_total++;
      end
   endtask

   task automatic results();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask

   // Bounded wait for both channels valid; a hang ends the run
   task automatic waitValid(input int hi);
      cnt = 0;
      while (!(dataValidA === 1'b1 && dataValidB === 1'b1) && cnt <= hi) begin
         tick(1);
         cnt++;
      end
      if (cnt > hi) begin
         chk("valid wait", 16'h0001, 16'h0000);
         results();
      end
   endtask

   task automatic wake(input logic [3:0] code, input int lo, input int hi);
      i_agoc_host_model.putPower(1'b1, 1'b0, code, 3'h0);
      tick(8);
      i_agoc_host_model.putPower(1'b1, 1'b0, PS_NORMAL, 3'h0);
      waitValid(hi + 20);
      chk("wake cycles", 16'h0001, 16'(cnt >= lo && cnt <= hi));
   endtask

   // ==========================================
   // Sequence
   initial begin
      tick(8);
      sys_rst = 1'b0;
      tick(2);
      chk("gainApplied", 16'h0000, 16'(gainApplied));
      chk("fullScaleMv", 16'h07D0, fullScaleMv);
      for (int i = 0; i < 5; i++) begin
         i_agoc_host_model.putGain(G_IN[i]);
         tick(3);
         chk("gainApplied", 16'(G_OUT[i]), 16'(gainApplied));
         chk("fullScaleMv", FS[i], fullScaleMv);
      end
      for (int i = 0; i < 15; i++) begin
         i_agoc_host_model.putPower(P_SM[i], P_LS[i], P_SM[i] ? P_C[i] : PS_NORMAL,
            P_C[i][2:0]);
         tick(8);
         chk("power state", 16'(P_E[i]), 16'(pwr & P_M[i]));
         // Interleave running for some cycles: the phase must flip on the very next cycle
         if (i == 8) begin
            ph = phaseA;
            tick(1);
            chk("sharedBusPhaseA", 16'(!ph), 16'(phaseA));
         end
      end
      wake(PS_GPD, WAKE - 2, WAKE + 4);
      wake(PS_STBY_B, int'(WAKE_STBY_CYC) - 2, int'(WAKE_STBY_CYC) + 4);
      i_agoc_host_model.setTick(1'b0);
      tick(150);
      chk("lowPowerClk", 16'h0000, 16'(lowPowerClk));
      tick(110);
      chk("lowPowerClk", 16'h0001, 16'(lowPowerClk));
      chk("dataValidA", 16'h0000, 16'(dataValidA));
      i_agoc_host_model.setTick(1'b1);
      tick(10);
      chk("lowPowerClk", 16'h0000, 16'(lowPowerClk));
      i_agoc_host_model.putGain(4'h0);
      i_agoc_host_model.putSamp(11'h12C, 11'h000);
      waitValid(300);
      tick(4);
      chk("sampOut.a", 16'h012C, 16'(sampOut.a));
      i_agoc_host_model.putCorr(1'b1, 4'h1);
      tick(2000);
      chk("sampOut.a", 16'h012B, 16'(sampOut.a));
      i_agoc_host_model.putCorr(1'b1, 4'hC);
      tick(5);
      chk("sampOut.a", 16'h012B, 16'(sampOut.a));
      i_agoc_host_model.putCorr(1'b1, 4'h0);
      tick(5);
      chk("sampOut.a", 16'h012A, 16'(sampOut.a));
      tick(10000);
      chk("sampOut.a", 16'h0122, 16'(sampOut.a));
      i_agoc_host_model.putCorr(1'b0, 4'h0);
      i_agoc_host_model.putSamp(11'h064, 11'h000);
      tick(2000);
      chk("sampOut.a", 16'h005A, 16'(sampOut.a));
      chk("sampOut.b", 16'h0000, 16'(sampOut.b));
      results();
   end
endmodule // agoc_ctrl_tb_top
